/* File: shared/tcw_pkg.sv */
// Constants shared by the timer, compare and waveform logic.
// Notes on behaviour
// - Counter write blocks matches at next tick.
// - Wave state survives waveform mode changes.
// - Action select is unbuffered, applies next match.
// - Reset clears the wave state to zero.
// - Nonzero action select puts wave on pin.
// - Action select zero leaves wave unchanged.
// - Force strobe applies action in non-PWM modes.
// - Normal mode counts up and wraps.
// - Normal mode overflow set when a tick wraps count from max to zero.
// - Clear-on-match mode clears count at compare.
// - Clear-on-match compare writes apply immediately.
// - Clear-on-match toggle inverts wave per match.
// - Clear-on-match overflow set on max to zero.
// - Fast PWM counts up to max, then clears.
// - Fast PWM select 2/3 clear/set, reverse at bottom.
// - Fast PWM overflow set when count leaves max for bottom.
// - Fast PWM extremes give spike or constant level.
// - Equality sets match flag at that tick.
// - PWM compare writes buffered until bottom.
// - Clock source zero stops the counter.
// - Forced match touches only the wave state.
package tcw_pkg;

  localparam int unsigned CNT_W = 8;

  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_STEP   = 8'h01;
  localparam logic [7:0] CNT_RST    = 8'h00;

  localparam logic [1:0] MODE_NORMAL    = 2'h0;
  localparam logic [1:0] MODE_PHASE     = 2'h1;
  localparam logic [1:0] MODE_MATCH_CLR = 2'h2;
  localparam logic [1:0] MODE_FAST      = 2'h3;

  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  localparam logic [2:0] CS_STOP = 3'h0;

  localparam logic WAVE_RST = 1'h0;
  localparam logic FLAG_RST = 1'h0;

endpackage

/* File: shared/tcw_wave_if.sv */
// Carrier between the counter core and the waveform generator.
`timescale 1ns/100ps
`default_nettype none
interface tcw_wave_if;
  logic       match_ev;
  logic       bottom_ev;
  logic       force_ev;
  logic       pwm_mode;
  logic [1:0] action_sel;
  logic       wave;

  modport ctl (
    output match_ev,
    output bottom_ev,
    output force_ev,
    output pwm_mode,
    output action_sel,
    input  wave
  );

  modport gen (
    input  match_ev,
    input  bottom_ev,
    input  force_ev,
    input  pwm_mode,
    input  action_sel,
    output wave
  );
endinterface
`default_nettype wire

/* File: src/tcw_wave_gen.sv */
// Waveform generator holding the internal wave output state.
`timescale 1ns/100ps
`default_nettype none
module tcw_wave_gen (
  input  wire logic mclk_in,
  input  wire logic resetn_in,
  tcw_wave_if.gen   wif
);

  logic wave;
  logic next_wave;
  logic act_ev;

  assign wif.wave = wave;

  // A forced match only acts outside the PWM modes and only on the wave state.
  assign act_ev = wif.match_ev || (wif.force_ev && !wif.pwm_mode);

  always_comb begin
    next_wave = wave;
    if (wif.pwm_mode) begin
      // Bottom is applied after the match so a compare at max gives a steady level.
      if (wif.match_ev) begin
        case (wif.action_sel)
          tcw_pkg::ACT_CLEAR: next_wave = 1'b0;
          tcw_pkg::ACT_SET:   next_wave = 1'b1;
          default:            next_wave = wave;
        endcase
      end
      if (wif.bottom_ev) begin
        case (wif.action_sel)
          tcw_pkg::ACT_CLEAR: next_wave = 1'b1;
          tcw_pkg::ACT_SET:   next_wave = 1'b0;
          default:            next_wave = next_wave;
        endcase
      end
    end else if (act_ev) begin
      case (wif.action_sel)
        tcw_pkg::ACT_TOGGLE: next_wave = !wave;
        tcw_pkg::ACT_CLEAR:  next_wave = 1'b0;
        tcw_pkg::ACT_SET:    next_wave = 1'b1;
        default:             next_wave = wave;
      endcase
    end
  end

  // The state is not touched by a mode change; only events move it.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wave <= tcw_pkg::WAVE_RST;
    end else begin
      wave <= next_wave;
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  hold_on_none_a: assert property (
    (wif.action_sel == tcw_pkg::ACT_NONE) |=> $stable(wave))
    else $error("wave state moved with no action selected");

  match_toggle_a: assert property (
    (!wif.pwm_mode && wif.match_ev && wif.action_sel == tcw_pkg::ACT_TOGGLE)
    |=> (wave != $past(wave)))
    else $error("wave did not toggle on match");

  fast_bottom_a: assert property (
    (wif.pwm_mode && wif.bottom_ev && wif.action_sel == tcw_pkg::ACT_CLEAR) |=> wave)
    else $error("non-inverted wave not set at bottom");

  fast_match_a: assert property (
    (wif.pwm_mode && wif.match_ev && !wif.bottom_ev && wif.action_sel == tcw_pkg::ACT_SET) |=> wave)
    else $error("inverted wave not set on match");

  force_set_a: assert property (
    (!wif.pwm_mode && wif.force_ev && wif.action_sel == tcw_pkg::ACT_SET) |=> wave)
    else $error("force strobe did not set wave");

  force_pwm_a: assert property (
    (wif.pwm_mode && wif.force_ev && !wif.match_ev && !wif.bottom_ev) |=> $stable(wave))
    else $error("force strobe acted in a PWM mode");

endmodule
`default_nettype wire

/* File: src/tcw_timer.sv */
// Eight-bit timer/counter with one compare unit and a waveform pin.
`timescale 1ns/100ps
`default_nettype none
module tcw_timer (
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic       timer_tick_in,
  input  wire logic [2:0] clock_source_sel_in,
  input  wire logic [1:0] wave_mode_sel_in,
  input  wire logic [1:0] output_action_sel_in,
  input  wire logic       force_match_strobe_in,
  input  wire logic       count_wr_in,
  input  wire logic [7:0] count_wdata_in,
  input  wire logic       compare_wr_in,
  input  wire logic [7:0] compare_wdata_in,
  input  wire logic       overflow_clr_in,
  input  wire logic       match_clr_in,
  input  wire logic       pin_direction_bit_in,
  input  wire logic       port_data_in,
  output logic      [7:0] count_value_out,
  output logic      [7:0] compare_value_out,
  output logic            overflow_flag_out,
  output logic            match_flag_out,
  output logic            wave_output_out,
  output logic            pin_out,
  output logic            pin_oe_out
);

  tcw_wave_if wif ();

  logic [7:0] count;
  logic [7:0] next_count;
  logic [7:0] cmp_buf;
  logic [7:0] cmp_act;
  logic       block;
  logic       tick;
  logic       is_pwm;
  logic       at_max;
  logic       equal;
  logic       match_ev;
  logic       wrap_ev;
  logic       ovf_set;
  logic       wave;

  // The tick is a one-cycle enable; with no source selected it never fires.
  assign tick   = timer_tick_in && (clock_source_sel_in != tcw_pkg::CS_STOP);
  assign is_pwm = wave_mode_sel_in[0];
  assign at_max = (count == tcw_pkg::CNT_MAX);
  assign equal  = (count == cmp_act);

  // A pending counter write hides the first tick's equality.
  assign match_ev = tick && equal && !block;

  // The counter leaves max on this tick unless a write overrides it.
  assign wrap_ev = tick && !count_wr_in && at_max;
  assign ovf_set = wrap_ev;

  assign wif.match_ev   = match_ev;
  assign wif.bottom_ev  = wrap_ev && (wave_mode_sel_in == tcw_pkg::MODE_FAST);
  assign wif.force_ev   = force_match_strobe_in;
  assign wif.pwm_mode   = is_pwm;
  assign wif.action_sel = output_action_sel_in;
  assign wave           = wif.wave;

  tcw_wave_gen u_wave (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .wif       (wif.gen)
  );

  always_comb begin
    next_count = count;
    if (tick) begin
      case (wave_mode_sel_in)
        tcw_pkg::MODE_NORMAL: begin
          next_count = 8'(count + tcw_pkg::CNT_STEP);
        end
        tcw_pkg::MODE_MATCH_CLR: begin
          if (match_ev) begin
            next_count = tcw_pkg::CNT_BOTTOM;
          end else begin
            next_count = 8'(count + tcw_pkg::CNT_STEP);
          end
        end
        tcw_pkg::MODE_FAST: begin
          if (at_max) begin
            next_count = tcw_pkg::CNT_BOTTOM;
          end else begin
            next_count = 8'(count + tcw_pkg::CNT_STEP);
          end
        end
        default: begin
          next_count = 8'(count + tcw_pkg::CNT_STEP);
        end
      endcase
    end
  end

  // A processor write beats any count or clear in the same cycle.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count <= tcw_pkg::CNT_RST;
    end else if (count_wr_in) begin
      count <= count_wdata_in;
    end else begin
      count <= next_count;
    end
  end

  // The block waits for the next tick even while the timer is stopped.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      block <= 1'b0;
    end else if (count_wr_in) begin
      block <= 1'b1;
    end else if (tick) begin
      block <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmp_buf <= tcw_pkg::CNT_RST;
    end else if (compare_wr_in) begin
      cmp_buf <= compare_wdata_in;
    end
  end

  // Outside PWM the active compare follows writes at once; in PWM only at bottom.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmp_act <= tcw_pkg::CNT_RST;
    end else if (!is_pwm) begin
      cmp_act <= compare_wr_in ? compare_wdata_in : cmp_buf;
    end else if (wrap_ev) begin
      cmp_act <= cmp_buf;
    end
  end

  // Hardware sets win over a clear in the same cycle.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      match_flag_out <= tcw_pkg::FLAG_RST;
    end else if (match_ev) begin
      match_flag_out <= 1'b1;
    end else if (match_clr_in) begin
      match_flag_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      overflow_flag_out <= tcw_pkg::FLAG_RST;
    end else if (ovf_set) begin
      overflow_flag_out <= 1'b1;
    end else if (overflow_clr_in) begin
      overflow_flag_out <= 1'b0;
    end
  end

  // The port override does not depend on the waveform mode.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_out    <= 1'b0;
      pin_oe_out <= 1'b0;
    end else begin
      if (output_action_sel_in != tcw_pkg::ACT_NONE) begin
        pin_out <= wave;
      end else begin
        pin_out <= port_data_in;
      end
      pin_oe_out <= pin_direction_bit_in;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_value_out   <= tcw_pkg::CNT_RST;
      compare_value_out <= tcw_pkg::CNT_RST;
      wave_output_out   <= tcw_pkg::WAVE_RST;
    end else begin
      count_value_out   <= count;
      compare_value_out <= cmp_buf;
      wave_output_out   <= wave;
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  write_block_a: assert property (
    (block && tick && !count_wr_in && !match_flag_out && !match_clr_in)
    |=> !match_flag_out)
    else $error("match not blocked after counter write");

  stop_hold_a: assert property (
    (clock_source_sel_in == tcw_pkg::CS_STOP && !count_wr_in) |=> $stable(count))
    else $error("counter moved with no clock source");

  normal_wrap_a: assert property (
    (wave_mode_sel_in == tcw_pkg::MODE_NORMAL && tick && !count_wr_in && at_max)
    |=> (count == tcw_pkg::CNT_BOTTOM))
    else $error("normal mode did not wrap to zero");

  ovf_wrap_a: assert property (
    (tick && !count_wr_in && at_max) |=> overflow_flag_out)
    else $error("overflow flag not set on wrap");

  ovf_quiet_a: assert property (
    (!overflow_flag_out && !(tick && at_max)) |=> !overflow_flag_out)
    else $error("overflow flag set without wrap");

  match_clear_a: assert property (
    (wave_mode_sel_in == tcw_pkg::MODE_MATCH_CLR && match_ev && !count_wr_in)
    |=> (count == tcw_pkg::CNT_BOTTOM))
    else $error("count not cleared on compare match");

  direct_compare_a: assert property (
    (wave_mode_sel_in == tcw_pkg::MODE_MATCH_CLR && compare_wr_in)
    |=> (cmp_act == $past(compare_wdata_in)))
    else $error("compare write not applied at once");

  fast_clear_a: assert property (
    (wave_mode_sel_in == tcw_pkg::MODE_FAST && tick && !count_wr_in && at_max)
    |=> (count == tcw_pkg::CNT_BOTTOM) ##1 (count == tcw_pkg::CNT_BOTTOM || $past(tick) || $past(count_wr_in)))
    else $error("fast mode did not restart from bottom");

  pwm_buffer_a: assert property (
    (is_pwm && $past(is_pwm) && !wrap_ev) |=> $stable(cmp_act))
    else $error("active compare changed away from bottom");

  match_flag_a: assert property (
    match_ev |=> match_flag_out)
    else $error("match flag not set on match");

  force_flag_a: assert property (
    (force_match_strobe_in && !match_ev && !match_flag_out) |=> !match_flag_out)
    else $error("forced match set the match flag");

  write_prio_a: assert property (
    count_wr_in |=> (count == $past(count_wdata_in)))
    else $error("counter write lost");

  pin_override_a: assert property (
    (output_action_sel_in != tcw_pkg::ACT_NONE) |=> (pin_out == $past(wave)))
    else $error("pin not driven from wave state");

  pin_dir_a: assert property (
    1'b1 |=> (pin_oe_out == $past(pin_direction_bit_in)))
    else $error("pin enable does not follow direction bit");

  blocked_tick_a: assert property (
    (wave_mode_sel_in == tcw_pkg::MODE_MATCH_CLR && block && tick && !count_wr_in)
    |=> (count == 8'($past(count) + tcw_pkg::CNT_STEP)))
    else $error("blocked tick cleared the counter");

  normal_step_a: assert property (
    (wave_mode_sel_in == tcw_pkg::MODE_NORMAL && tick && !count_wr_in)
    |=> (count == 8'($past(count) + tcw_pkg::CNT_STEP)))
    else $error("normal mode did not step by one");

  match_mode_step_a: assert property (
    (wave_mode_sel_in == tcw_pkg::MODE_MATCH_CLR && tick && !count_wr_in && !match_ev)
    |=> (count == 8'($past(count) + tcw_pkg::CNT_STEP)))
    else $error("clear-on-match mode did not step by one");

  fast_step_a: assert property (
    (wave_mode_sel_in == tcw_pkg::MODE_FAST && tick && !count_wr_in && !at_max)
    |=> (count == 8'($past(count) + tcw_pkg::CNT_STEP)))
    else $error("fast mode did not step by one");

  ovf_sticky_a: assert property (
    (overflow_flag_out && !overflow_clr_in)
    |=> overflow_flag_out)
    else $error("overflow flag cleared by hardware");

  match_sticky_a: assert property (
    (match_flag_out && !match_clr_in)
    |=> match_flag_out)
    else $error("match flag cleared by hardware");

  stop_match_a: assert property (
    (clock_source_sel_in == tcw_pkg::CS_STOP && !match_flag_out)
    |=> !match_flag_out)
    else $error("match flag set with no clock source");

  pwm_load_a: assert property (
    (is_pwm && wrap_ev)
    |=> (cmp_act == $past(cmp_buf)))
    else $error("active compare not loaded at bottom");

  pin_port_a: assert property (
    (output_action_sel_in == tcw_pkg::ACT_NONE)
    |=> (pin_out == $past(port_data_in)))
    else $error("pin not driven from port value");

  force_count_a: assert property (
    (force_match_strobe_in && !tick && !count_wr_in)
    |=> $stable(count))
    else $error("forced match moved the counter");

  write_ovf_a: assert property (
    (count_wr_in && !overflow_flag_out)
    |=> !overflow_flag_out)
    else $error("overflow flag set on a counter write");

endmodule
`default_nettype wire

/* File: bench/tcw_tick_src.sv */
// Prescaler model that hands the timer one-cycle tick pulses.
`timescale 1ns/100ps
`default_nettype none
module tcw_tick_src #(
  parameter int DIV = 4
) (
  input  wire logic mclk_in,
  input  wire logic resetn_in,
  input  wire logic run_in,
  output logic      tick_out
);
  int div_cnt;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_cnt  <= 0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= run_in && (div_cnt == DIV - 1);
      div_cnt  <= (div_cnt == DIV - 1) ? 0 : div_cnt + 1;
    end
  end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the timer, compare and waveform block.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [3:0] WCN = 4'h1;
  localparam logic [3:0] WCM = 4'h2;
  localparam logic [3:0] FRC = 4'h4;
  localparam logic [3:0] CLR = 4'h8;
  logic       mclk_in, resetn_in, man_tick, ps_tick, ps_run;
  logic [2:0] cs;
  logic [1:0] mode, act;
  logic       force_s, cnt_wr, cmp_wr, ovf_clr, mat_clr, dir, port_d;
  logic [7:0] cnt_d, cmp_d, cnt_q, cmp_q;
  logic       ovf, mat, wave, pin, pin_oe;
  int         n_fail, total_checks, hi;
  logic [1:0] f_act [6] = '{2'h3, 2'h0, 2'h2, 2'h0, 2'h1, 2'h1};
  logic       f_exp [6] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
  logic [1:0] s_act [4] = '{2'h3, 2'h3, 2'h2, 2'h2};
  logic [7:0] s_cmp [4] = '{8'hFF, 8'h00, 8'hFF, 8'h00};
  int         s_hi  [4] = '{0, 1020, 1024, 4};

  tcw_tick_src #(.DIV(4)) u_tcw_tick_src (
    .mclk_in  (mclk_in),
    .resetn_in(resetn_in),
    .run_in   (ps_run),
    .tick_out (ps_tick)
  );

  tcw_timer u_tcw_timer (
    .mclk_in              (mclk_in),
    .resetn_in            (resetn_in),
    .timer_tick_in        (man_tick | ps_tick),
    .clock_source_sel_in  (cs),
    .wave_mode_sel_in     (mode),
    .output_action_sel_in (act),
    .force_match_strobe_in(force_s),
    .count_wr_in          (cnt_wr),
    .count_wdata_in       (cnt_d),
    .compare_wr_in        (cmp_wr),
    .compare_wdata_in     (cmp_d),
    .overflow_clr_in      (ovf_clr),
    .match_clr_in         (mat_clr),
    .pin_direction_bit_in (dir),
    .port_data_in         (port_d),
    .count_value_out      (cnt_q),
    .compare_value_out    (cmp_q),
    .overflow_flag_out    (ovf),
    .match_flag_out       (mat),
    .wave_output_out      (wave),
    .pin_out              (pin),
    .pin_oe_out           (pin_oe)
  );

  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge mclk_in);
    #1;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk_in);
      man_tick <= 1'b1;
      @(posedge mclk_in);
      man_tick <= 1'b0;
    end
    settle();
  endtask

  // Strobe bits: count write, compare write, force, flag clear.
  task automatic strobe(input logic [3:0] s, input logic [7:0] d);
    @(posedge mclk_in);
    {mat_clr, ovf_clr, force_s, cmp_wr, cnt_wr} <= {s[3], s};
    cnt_d <= d;
    cmp_d <= d;
    @(posedge mclk_in);
    {mat_clr, ovf_clr, force_s, cmp_wr, cnt_wr} <= 5'h00;
    settle();
  endtask

  task automatic cfg(input logic [2:0] c, input logic [1:0] m, input logic [1:0] a);
    @(posedge mclk_in);
    cs   <= c;
    mode <= m;
    act  <= a;
    settle();
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge mclk_in);
    n_fail++;
    wrap_up();
  end

  initial begin
    resetn_in = 1'b0;
    man_tick  = 1'b0;
    ps_run    = 1'b0;
    cs        = 3'h1;
    mode      = tcw_pkg::MODE_NORMAL;
    act       = tcw_pkg::ACT_NONE;
    {mat_clr, ovf_clr, force_s, cmp_wr, cnt_wr} = 5'h00;
    {dir, port_d, cnt_d, cmp_d} = 18'h00000;
    repeat (20) @(posedge mclk_in);
    resetn_in <= 1'b1;
    settle();
    chk({wave, pin_oe, ovf, mat, cnt_q}, 16'h0000);
    strobe(WCN, 8'hFE);
    tick(1);
    chk({ovf, cnt_q}, 16'h00FF);
    tick(1);
    chk({ovf, cnt_q}, 16'h0100);
    cfg(3'h0, tcw_pkg::MODE_NORMAL, tcw_pkg::ACT_NONE);
    tick(3);
    chk(cnt_q, 16'h0000);
    strobe(WCN, 8'h10);
    chk(cnt_q, 16'h0010);
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk_in);
      act <= f_act[i];
      strobe(FRC, 8'h00);
      chk({mat, cnt_q, wave}, {7'h00, 8'h10, f_exp[i]});
    end
    cfg(3'h0, tcw_pkg::MODE_NORMAL, tcw_pkg::ACT_TOGGLE);
    strobe(WCM | CLR, 8'h10);
    strobe(WCN, 8'h10);
    cfg(3'h1, tcw_pkg::MODE_NORMAL, tcw_pkg::ACT_TOGGLE);
    tick(1);
    chk({mat, wave, cnt_q}, 16'h0011);
    cfg(3'h1, tcw_pkg::MODE_MATCH_CLR, tcw_pkg::ACT_TOGGLE);
    strobe(WCM, 8'h05);
    strobe(WCN | CLR, 8'h08);
    tick(248);
    chk({ovf, mat, cnt_q}, 16'h0200);
    tick(5);
    chk(cnt_q, 16'h0005);
    tick(1);
    chk({mat, wave, cnt_q}, 16'h0300);
    cfg(3'h1, tcw_pkg::MODE_NORMAL, tcw_pkg::ACT_TOGGLE);
    chk(wave, 16'h0001);
    cfg(3'h1, tcw_pkg::MODE_MATCH_CLR, tcw_pkg::ACT_TOGGLE);
    @(posedge mclk_in);
    dir <= 1'b1;
    settle();
    chk({pin, pin_oe}, 16'h0003);
    cfg(3'h1, tcw_pkg::MODE_MATCH_CLR, tcw_pkg::ACT_NONE);
    @(posedge mclk_in);
    dir <= 1'b0;
    settle();
    chk({pin, pin_oe}, 16'h0000);
    cfg(3'h1, tcw_pkg::MODE_MATCH_CLR, tcw_pkg::ACT_CLEAR);
    tick(6);
    chk({wave, cnt_q}, 16'h0000);
    @(posedge mclk_in);
    port_d <= 1'b1;
    cfg(3'h1, tcw_pkg::MODE_MATCH_CLR, tcw_pkg::ACT_NONE);
    chk(pin, 16'h0001);
    cfg(3'h1, tcw_pkg::MODE_NORMAL, tcw_pkg::ACT_SET);
    strobe(FRC, 8'h00);
    strobe(WCM, 8'h80);
    cfg(3'h1, tcw_pkg::MODE_FAST, tcw_pkg::ACT_CLEAR);
    strobe(WCN | CLR, 8'h7E);
    tick(2);
    chk({wave, cnt_q}, 16'h0180);
    tick(1);
    chk({mat, wave, cnt_q}, 16'h0281);
    strobe(WCM | CLR, 8'h10);
    chk(cmp_q, 16'h0010);
    strobe(WCN, 8'h0F);
    tick(2);
    chk(mat, 16'h0000);
    strobe(WCN | CLR, 8'hFD);
    tick(2);
    chk({ovf, cnt_q}, 16'h00FF);
    tick(1);
    chk({ovf, wave, cnt_q}, 16'h0300);
    tick(16);
    chk({wave, cnt_q}, 16'h0110);
    tick(1);
    chk(wave, 16'h0000);
    cfg(3'h0, tcw_pkg::MODE_FAST, tcw_pkg::ACT_SET);
    strobe(FRC, 8'h00);
    chk(wave, 16'h0000);
    @(posedge mclk_in);
    ps_run <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      cfg(3'h1, tcw_pkg::MODE_FAST, s_act[i]);
      strobe(WCM, s_cmp[i]);
      repeat (1100) @(posedge mclk_in);
      hi = 0;
      repeat (1024) begin
        @(posedge mclk_in);
        hi += (wave === 1'b1) ? 1 : 0;
      end
      chk(16'(hi), 16'(s_hi[i]));
    end
    wrap_up();
  end
endmodule
`default_nettype wire
